// ==== dv/panel_model.sv ====
/* Panel model: answers reads with a fixed word.
   Assumes active-low select and read strobe from the port. */
`timescale 1ns/1ps
`default_nettype none
module panel_model
#(
    parameter logic [15:0] RD_WORD = 16'hc35a
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic panel_cs_n,
    input wire logic panel_re_n,
    output logic [15:0] panel_data_in
);
    // Toggles when not read-selected
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            panel_data_in <= 16'h0f0f;
        else if (!panel_cs_n && !panel_re_n)
            panel_data_in <= RD_WORD;
        else
            panel_data_in <= ~panel_data_in;
    end
endmodule // panel_model
`default_nettype wire

// ==== dv/panel_pacing_checker.sv ====
/* Port assertions for the panel pacing block, bound into its top module.
   Assumes one clock domain and config held steady during accesses. */
`timescale 1ns/1ps
`default_nettype none
module panel_pacing_checker
    import panel_pacing_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire panel_port_config_t panel_port_config,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic rd_valid,
    input wire logic [15:0] rd_data,
    input wire logic panel_cs_n,
    input wire logic panel_we_n,
    input wire logic panel_re_n,
    input wire logic panel_data_oe,
    input wire logic busy
);
    // ********************
    // Expected lengths
    // ********************
    panel_port_config_t c;
    logic [3:0] base;
    logic [3:0] n_w;
    logic [3:0] n_r;
    logic [4:0] low_cnt;
    assign c = panel_port_config;
    always_comb
    begin
        if (c.panel_cycle_pattern == PAT_2PIX_3CYC)
            base = 4'h6;
        else if (c.from_display)
            base = (c.panel_cycle_pattern == PAT_1PIX_1CYC) ? 4'h4 : 4'h3;
        else if (c.panel_cycle_pattern == PAT_1PIX_1CYC && !c.two_pixels_per_bus_word)
            base = 4'h5;
        else
            base = 4'h4;
    end
    assign n_w = (c.write_cycle_time > base) ? c.write_cycle_time : base;
    assign n_r = (c.read_cycle_time > base) ? c.read_cycle_time : base;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            low_cnt <= 5'h00;
        else
            low_cnt <= panel_cs_n ? 5'h00 : low_cnt + 5'h01;
    end
    // ********************
    // Properties
    // ********************
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence access_end;
        panel_cs_n && $past(!panel_cs_n);
    endsequence
    sequence push_idle;
        req_valid && req_ready && !busy && panel_cs_n;
    endsequence
    len_write_a: assert property (access_end ##0 $past(!panel_we_n)
        |-> low_cnt == {1'b0, n_w} || low_cnt == {n_w, 1'b0}) else $error("write length off");
    len_read_a: assert property (access_end ##0 $past(!panel_re_n)
        |-> low_cnt == {1'b0, n_r}) else $error("read length off");
    merge_limit_a: assert property (!panel_cs_n
        |-> low_cnt < {n_w, 1'b0} || low_cnt < {1'b0, n_r}) else $error("accesses merged");
    rdv_end_a: assert property (rd_valid
        |-> access_end ##0 $past(!panel_re_n)) else $error("read data not at read end");
    rd_hold_a: assert property ($changed(rd_data) |-> rd_valid)
        else $error("read data moved");
    strobe_one_a: assert property (!panel_cs_n |-> panel_re_n != panel_we_n)
        else $error("strobes wrong while selected");
    idle_strobe_a: assert property (panel_cs_n
        |-> panel_we_n && panel_re_n && !panel_data_oe) else $error("strobe while idle");
    oe_write_a: assert property (!panel_cs_n |-> panel_data_oe == !panel_we_n)
        else $error("drive enable wrong");
    start_bound_a: assert property (push_idle |-> ##[1:4] !panel_cs_n)
        else $error("access did not start");
endmodule // panel_pacing_checker
bind panel_port_cycle_pacing panel_pacing_checker panel_pacing_checker_i (.clk, .rst_n,
    .panel_port_config, .req_valid, .req_ready, .rd_valid, .rd_data, .panel_cs_n,
    .panel_we_n, .panel_re_n, .panel_data_oe, .busy);
`default_nettype wire

// ==== dv/panel_port_cycle_pacing_tb.sv ====
/* Directed testbench for the pacing block with a panel model.
   Assumes the 40 MHz clock and the active-low reset of the block. */
`timescale 1ns/1ps
`default_nettype none
module panel_port_cycle_pacing_tb;
    import panel_pacing_pkg::*;
    localparam logic [15:0] RD_WORD = 16'ha5c3;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0;
    panel_port_config_t cfg = '0;
    access_req_t req = '0;
    logic req_ready, rd_valid, panel_cs_n, panel_we_n, panel_re_n, panel_data_oe, busy;
    logic [15:0] rd_data, panel_data_out, panel_data_in, lo, hi, len;
    int fails = 0;
    int num_checks = 0;
    always #12.5 clk = ~clk;
    panel_port_cycle_pacing panel_port_cycle_pacing_i (.clk, .rst_n, .panel_port_config(cfg),
        .req_valid, .req_ready, .req, .rd_valid, .rd_data, .panel_cs_n, .panel_we_n,
        .panel_re_n, .panel_data_out, .panel_data_oe, .panel_data_in, .busy);
    panel_model #(.RD_WORD(RD_WORD)) panel_model_i (.clk, .rst_n, .panel_cs_n, .panel_re_n,
        .panel_data_in);
    // ********************
    // Helpers
    // ********************
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    function automatic logic [15:0] exp_min(logic src, logic [1:0] pat, logic two);
        if (pat == 2'h3)
            return 16'h0006;
        if (src)
            return (pat == 2'h0) ? 16'h0004 : 16'h0003;
        return (pat == 2'h0 && !two) ? 16'h0005 : 16'h0004;
    endfunction
    // Push one request, then time its select-low window
    task automatic access(logic [11:0] c, access_req_t r);
        @(posedge clk);
        cfg <= c;
        req_valid <= 1'b1;
        req <= r;
        @(negedge clk);
        while (!req_ready)
            @(negedge clk);
        @(posedge clk);
        req_valid <= 1'b0;
        len = 16'h0000;
        for (int i = 0; i < 20 && panel_cs_n; i++)
            @(negedge clk);
        while (!panel_cs_n && len < 16'h0028)
        begin
            if (len == 16'h0000)
                lo = panel_data_out;
            hi = panel_data_out;
            len++;
            @(negedge clk);
        end
    endtask
    // ********************
    // Scenarios
    // ********************
    task automatic table_sweep();
        for (int k = 0; k < 16; k++)
        begin
            access({k[3:0], 8'h00}, {2'b00, 16'h0000, k[15:0]});
            check("min length", len, exp_min(k[3], k[2:1], k[0]));
        end
    endtask
    task automatic read_write();
        access(12'h1b0, {2'b11, 32'h0000_0000});
        check("read length", len, 16'h000b);
        check("read valid", {15'h0000, rd_valid}, 16'h0001);
        check("read data", rd_data, RD_WORD);
        access(12'h009, {2'b00, 32'h0000_7e81});
        check("write length", len, 16'h0009);
        check("write data", lo, 16'h7e81);
    endtask
    task automatic split_write();
        access(12'h200, {2'b01, 32'hbeef_1234});
        check("split length", len, 16'h0008);
        check("low half", lo, 16'h1234);
        check("high half", hi, 16'hbeef);
    endtask
    task automatic fifo_fill();
        logic [15:0] acc;
        logic [15:0] run;
        logic [15:0] longest;
        acc = 16'h0000;
        run = 16'h0000;
        longest = 16'h0000;
        @(posedge clk);
        cfg <= 12'h00f;
        req_valid <= 1'b1;
        req <= '0;
        @(negedge clk);
        while (req_ready && acc < 16'h0008)
        begin
            acc++;
            @(posedge clk);
            @(negedge clk);
        end
        check("refused", {15'h0000, acc == 16'h0004 || acc == 16'h0005}, 16'h0001);
        check("busy full", {15'h0000, busy}, 16'h0001);
        while (!req_ready)
            @(negedge clk);
        @(posedge clk);
        req_valid <= 1'b0;
        for (int i = 0; i < 300 && busy !== 1'b0; i++)
        begin
            @(negedge clk);
            run = panel_cs_n ? 16'h0000 : run + 16'h0001;
            longest = (run > longest) ? run : longest;
        end
        check("drained", {15'h0000, busy}, 16'h0000);
        check("longest select", longest, 16'h000f);
    endtask
    initial
    begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        table_sweep();
        read_write();
        split_write();
        fifo_fill();
        finish_test();
    end
    initial
    begin
        #100000;
        fails++;
        finish_test();
    end
endmodule // panel_port_cycle_pacing_tb
`default_nettype wire

// ==== logic/pacing_fifo.sv ====
/*
 Small synchronous FIFO with valid and ready on both sides.
 Assumes a single clock; both sides handshake on the rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module pacing_fifo
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW:0] next_count;
    logic push;
    logic pop;

    assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'b1;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= next_count;
            in_ready <= (next_count != (AW+1)'(DEPTH));
        end
    end
endmodule // pacing_fifo
`default_nettype wire

// ==== logic/panel_pacing_pkg.sv ====
/*
 Constants and carrier types for the panel port pacing block.
 Assumes one 40 MHz interface clock and an active-low asynchronous reset.
*/
// Notes on behaviour
// [RQ1] Idle cycles may be inserted between accesses, set by configuration; the code fixes the gap at two cycles, GAP_CYCLES plus one idle cycle.
// [RQ2] Minimum cycle times count interface clocks with select and strobe held.
// [RQ3] Bus source, one pixel per cycle, one pixel per word: at least 5 cycles.
// [RQ4] Bus source, slower one-pixel patterns or two pixels per word: at least 4.
// [RQ5] Bus source, two pixels per three cycles: at least 6 cycles.
// [RQ6] Display source, one pixel per cycle: at least 4 cycles.
// [RQ7] Display source, one pixel per two or three cycles: at least 3 cycles.
// [RQ8] Display source, two pixels per three cycles: at least 6 cycles.
// [RQ9] Separate bus accesses are separated by at least one idle cycle.
// [RQ10] Read data returns, and select releases, at the end of read cycle time.
// [RQ11] Split 32-bit writes send two halves back to back under one select.
package panel_pacing_pkg;

    // ************************************************************
    // Encodings
    // ************************************************************
    typedef enum logic [1:0] {
        PAT_1PIX_1CYC,
        PAT_1PIX_2CYC,
        PAT_1PIX_3CYC,
        PAT_2PIX_3CYC
    } panel_cycle_pattern_t;

    typedef struct packed {
        logic from_display;
        panel_cycle_pattern_t panel_cycle_pattern;
        logic two_pixels_per_bus_word;
        logic [3:0] read_cycle_time;
        logic [3:0] write_cycle_time;
    } panel_port_config_t;

    typedef struct packed {
        logic is_read;
        logic split;
        logic [31:0] data;
    } access_req_t;

    // ************************************************************
    // Counts
    // ************************************************************
    localparam int CLK_MHZ = 40;
    localparam logic [3:0] MIN_CYC_BUS_FAST = 4'h5;
    localparam logic [3:0] MIN_CYC_BUS_SLOW = 4'h4;
    localparam logic [3:0] MIN_CYC_TWO_THREE = 4'h6;
    localparam logic [3:0] MIN_CYC_DISP_FAST = 4'h4;
    localparam logic [3:0] MIN_CYC_DISP_SLOW = 4'h3;
    localparam logic [3:0] GAP_CYCLES = 4'h1;
    localparam int FIFO_DEPTH = 4;
    localparam int REQ_W = 34;
    localparam logic [15:0] RESET_HALF = 16'h0000;

endpackage

// ==== logic/panel_port_cycle_pacing.sv ====
/*
 Paces accesses from the bus or display source onto the panel port.
 Assumes config is held steady while accesses run; panel read data is
 sampled on the last cycle of each read.
*/
`timescale 1ns/1ps
`default_nettype none
module panel_port_cycle_pacing
    import panel_pacing_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire panel_port_config_t panel_port_config,
    input wire logic req_valid,
    output logic req_ready,
    input wire access_req_t req,
    output logic rd_valid,
    output logic [15:0] rd_data,
    output logic panel_cs_n,
    output logic panel_we_n,
    output logic panel_re_n,
    output logic [15:0] panel_data_out,
    output logic panel_data_oe,
    input wire logic [15:0] panel_data_in,
    output logic busy
);
    // ************************************************************
    // Minimum cycle selection
    // ************************************************************
    function automatic logic [3:0] min_cycles(input panel_port_config_t c);
        logic [3:0] r;
        r = MIN_CYC_BUS_SLOW;
        if (c.panel_cycle_pattern == PAT_2PIX_3CYC)
        begin
            r = MIN_CYC_TWO_THREE; // [RQ5] [RQ8]
        end
        else if (c.from_display)
        begin
            r = (c.panel_cycle_pattern == PAT_1PIX_1CYC) ?
                MIN_CYC_DISP_FAST : MIN_CYC_DISP_SLOW; // [RQ6] [RQ7]
        end
        else if (c.panel_cycle_pattern == PAT_1PIX_1CYC && !c.two_pixels_per_bus_word)
        begin
            r = MIN_CYC_BUS_FAST; // [RQ3]
        end
        else
        begin
            r = MIN_CYC_BUS_SLOW; // [RQ4]
        end
        return r;
    endfunction

    function automatic logic [3:0] max4(input logic [3:0] a, input logic [3:0] b);
        return (a > b) ? a : b;
    endfunction

    // ************************************************************
    // Request FIFO
    // ************************************************************
    logic fifo_valid;
    logic fifo_pop;
    logic [REQ_W-1:0] fifo_data;
    access_req_t cur;

    pacing_fifo #(.WIDTH(REQ_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(req_valid),
        .in_ready(req_ready),
        .in_data(req),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    // ************************************************************
    // Access sequencer
    // ************************************************************
    typedef enum logic [1:0] {ST_IDLE, ST_ACCESS, ST_GAP} state_t;
    state_t state;
    logic [3:0] cnt;
    logic [3:0] span;
    logic second_half;
    logic last_cycle;

    assign fifo_pop = (state == ST_IDLE) && fifo_valid;
    assign last_cycle = (state == ST_ACCESS) && (cnt == span - 4'h1);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ST_IDLE;
            cnt <= '0;
            span <= '0;
            second_half <= 1'b0;
            cur <= '0;
        end
        else
        begin
            unique case (state)
                ST_IDLE:
                begin
                    if (fifo_valid)
                    begin
                        cur <= fifo_data;
                        cnt <= '0;
                        second_half <= 1'b0;
                        span <= max4(min_cycles(panel_port_config), // [RQ2]
                            fifo_data[REQ_W-1] ? panel_port_config.read_cycle_time
                                               : panel_port_config.write_cycle_time);
                        state <= ST_ACCESS;
                    end
                end
                ST_ACCESS:
                begin
                    if (last_cycle)
                    begin
                        cnt <= '0;
                        if (cur.split && !cur.is_read && !second_half)
                        begin
                            second_half <= 1'b1; // [RQ11]
                        end
                        else
                        begin
                            state <= ST_GAP; // [RQ9] [RQ10]
                        end
                    end
                    else
                    begin
                        cnt <= cnt + 4'h1;
                    end
                end
                ST_GAP:
                begin
                    if (cnt >= GAP_CYCLES - 4'h1)
                    begin
                        cnt <= '0;
                        state <= ST_IDLE; // [RQ9]
                    end
                    else
                    begin
                        cnt <= cnt + 4'h1;
                    end
                end
                default:
                begin
                    state <= ST_IDLE;
                    cnt <= '0;
                end
            endcase
        end
    end

    // ************************************************************
    // Panel pins, registered
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            panel_cs_n <= 1'b1;
            panel_we_n <= 1'b1;
            panel_re_n <= 1'b1;
            panel_data_out <= RESET_HALF;
            panel_data_oe <= 1'b0;
        end
        else
        begin
            if ((state == ST_IDLE && fifo_valid) || (state == ST_ACCESS && !(last_cycle
                && !(cur.split && !cur.is_read && !second_half))))
            begin
                panel_cs_n <= 1'b0; // [RQ11]
                panel_we_n <= (state == ST_IDLE) ? fifo_data[REQ_W-1] : cur.is_read;
                panel_re_n <= (state == ST_IDLE) ? !fifo_data[REQ_W-1] : !cur.is_read;
                panel_data_oe <= (state == ST_IDLE) ? !fifo_data[REQ_W-1] : !cur.is_read;
                if (state == ST_IDLE)
                begin
                    panel_data_out <= fifo_data[15:0];
                end
                else if (last_cycle)
                begin
                    panel_data_out <= cur.data[31:16];
                end
            end
            else
            begin
                panel_cs_n <= 1'b1; // [RQ10]
                panel_we_n <= 1'b1;
                panel_re_n <= 1'b1;
                panel_data_oe <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_valid <= 1'b0;
            rd_data <= RESET_HALF;
        end
        else
        begin
            rd_valid <= last_cycle && cur.is_read; // [RQ10]
            if (last_cycle && cur.is_read)
            begin
                rd_data <= panel_data_in;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy <= 1'b0;
        end
        else
        begin
            busy <= (state != ST_IDLE) || fifo_valid;
        end
    end
endmodule // panel_port_cycle_pacing
`default_nettype wire
